//--- tirq_top.sv
// Function
// - compare writes take high byte from shared latch, both halves together
// - capture low read latches high half; high read returns that latch
// - one temporary high-byte latch serves every sixteen-bit access
// - capture pin event loads count value except in capture-as-top mode; timer 1 may use comparator
// - capture register is driven out for use as counter top
// - mask register: bits 5,3,2,1,0 enables, others zero, reset zero
// - request only when enable, global enable and flag all set
// - flag register: bits 5,3,2,1,0 flags, others zero, reset zero
// - capture flag set on each detected capture pin event outside capture-as-top mode
// - in capture-as-top mode capture flag sets on reaching top
// - capture flag clears when its vector executes
// - writing one to capture flag clears it
// - compare C flag set the cycle after the match
// - forced compare C strobe never sets compare C flag
// - compare C flag clears on vector or written one
// - compare A and B flags behave like compare C
// - overflow flag set when the counter overflows
// - overflow flag clears on vector or written one
`default_nettype none
`include "tirq_map.svh"

module tirq_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tirq_pkg::tirq_cnt_t [3:0] count_value,
   input wire logic [3:0] capture_input_pin,
   input wire logic comparator_out,
   input wire logic [3:0] match_a,
   input wire logic [3:0] match_b,
   input wire logic [3:0] match_c,
   input wire logic [3:0] overflow,
   input wire logic [3:0] top_reached,
   input wire logic [3:0] capture_is_top,
   input wire tirq_pkg::tirq_src_t [3:0] vector_ack,
   output logic [3:0] capture_irq_request,
   output logic [3:0] compare_c_irq_request,
   output logic [3:0] compare_b_irq_request,
   output logic [3:0] compare_a_irq_request,
   output logic [3:0] overflow_irq_request,
   output tirq_pkg::tirq_cnt_t [3:0] capture_register,
   output tirq_pkg::tirq_cnt_t compare_wr_data,
   output tirq_pkg::tirq_cmp_t [3:0] compare_wr_strobe
);
   import tirq_pkg::*;

   // ****************************************************
   // field packing
   // ****************************************************
   // internal source order: 0 ovf, 1 A, 2 B, 3 C, 4 capture
   function automatic logic [7:0] to_byte(input tirq_src_t x);
      logic [7:0] b;
      b = 8'h00;
      b[`TIRQ_B_OVF] = x[0];
      b[`TIRQ_B_CMPA] = x[1];
      b[`TIRQ_B_CMPB] = x[2];
      b[`TIRQ_B_CMPC] = x[3];
      b[`TIRQ_B_CAP] = x[4];
      return b;
   endfunction : to_byte

   function automatic tirq_src_t from_byte(input logic [7:0] b);
      tirq_src_t x;
      x[0] = b[`TIRQ_B_OVF];
      x[1] = b[`TIRQ_B_CMPA];
      x[2] = b[`TIRQ_B_CMPB];
      x[3] = b[`TIRQ_B_CMPC];
      x[4] = b[`TIRQ_B_CAP];
      return x;
   endfunction : from_byte

   // ****************************************************
   // state
   // ****************************************************
   tirq_state_t st_q;
   tirq_state_t st_d;

   logic acc;
   logic wr;
   logic rd;
   logic hit_mask;
   logic hit_flag;
   logic hit_ctrl;
   logic hit_req;
   logic hit_tmr;
   logic [1:0] sel_t;
   logic [1:0] sel_r;
   logic [2:0] sub;
   logic [3:0] pin_evt;
   logic [3:0] cap_src;
   logic [4:0] lvl_new;
   logic [4:0] lvl_chg;
   tirq_src_t [3:0] req;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign sel_t = paddr[6:5];
   // mask and flag bytes sit one word apart, timer windows 32 bytes apart
   assign sel_r = paddr[3:2];
   assign sub = paddr[4:2];
   assign hit_mask = {paddr[11:4], 4'h0} == `TIRQ_MASK_BASE;
   assign hit_flag = {paddr[11:4], 4'h0} == `TIRQ_FLAG_BASE;
   assign hit_ctrl = {paddr[11:2], 2'b00} == `TIRQ_CTRL_OFS;
   assign hit_req = {paddr[11:2], 2'b00} == `TIRQ_REQ_OFS;
   assign hit_tmr = (paddr & `TIRQ_TMR_MASK) == `TIRQ_TMR_BASE;

   // ****************************************************
   // capture input qualification
   // ****************************************************
   // a change counts only once stages two and three agree
   assign lvl_chg = ~(st_q.s2 ^ st_q.s3) & (st_q.s3 ^ st_q.lvl);
   assign lvl_new = st_q.s3;

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_tmr
         if (g == 0)
         begin : g_ac
            assign cap_src[g] = st_q.acsel ? 1'b1 : 1'b0;
         end
         else
         begin : g_pin
            assign cap_src[g] = 1'b0;
         end
         // edge polarity chosen per timer in the control word
         assign pin_evt[g] = cap_src[g]
            ? lvl_chg[4] & (lvl_new[4] == st_q.rise[g])
            : lvl_chg[g] & (lvl_new[g] == st_q.rise[g]);
         assign req[g] = st_q.mask[g] & st_q.flag[g] & {5{st_q.gie}};
         assign overflow_irq_request[g] = req[g][0];
         assign compare_a_irq_request[g] = req[g][1];
         assign compare_b_irq_request[g] = req[g][2];
         assign compare_c_irq_request[g] = req[g][3];
         assign capture_irq_request[g] = req[g][4];
         assign capture_register[g] = st_q.cap[g];
      end
   endgenerate

   assign compare_wr_data = st_q.cw_data;
   assign compare_wr_strobe = st_q.cw_stb;

   // ****************************************************
   // bus answer
   // ****************************************************
   assign pready = 1'b1;
   assign pslverr = acc
      & ~(hit_mask | hit_flag | hit_ctrl | hit_req | hit_tmr);

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (rd & hit_mask)
      begin
         prdata[7:0] = to_byte(st_q.mask[sel_r]);
      end
      else if (rd & hit_flag)
      begin
         prdata[7:0] = to_byte(st_q.flag[sel_r]);
      end
      else if (rd & hit_ctrl)
      begin
         prdata[`TIRQ_C_GIE] = st_q.gie;
         prdata[`TIRQ_C_ACSEL] = st_q.acsel;
         prdata[`TIRQ_C_RISE_LO +: 4] = st_q.rise;
      end
      else if (rd & hit_req)
      begin
         for (int t = 0; t < 4; t++)
         begin
            prdata[8 * t +: 8] = to_byte(req[t]);
         end
      end
      else if (rd & hit_tmr)
      begin
         if (sub == `TIRQ_SUB_CAP_LO)
         begin
            prdata[7:0] = st_q.cap[sel_t][7:0];
         end
         else if (sub[0])
         begin
            prdata[7:0] = st_q.temp;
         end
      end
   end

   // ****************************************************
   // next state
   // ****************************************************
   always_comb
   begin
      tirq_src_t set;
      tirq_src_t clr;
      st_d = st_q;
      set = 5'h00;
      clr = 5'h00;
      st_d.s1 = {comparator_out, capture_input_pin};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.lvl = st_q.lvl ^ lvl_chg;
      st_d.cw_stb = '0;

      // ---- control, mask and latch traffic ----
      if (wr & hit_ctrl)
      begin
         st_d.gie = pwdata[`TIRQ_C_GIE];
         st_d.acsel = pwdata[`TIRQ_C_ACSEL];
         st_d.rise = pwdata[`TIRQ_C_RISE_LO +: 4];
      end
      if (wr & hit_mask)
      begin
         st_d.mask[sel_r] = from_byte(pwdata[7:0]);
      end
      if (acc & hit_tmr)
      begin
         if (pwrite & sub[0])
         begin
            st_d.temp = pwdata[7:0];
         end
         else if (pwrite & (sub == `TIRQ_SUB_CAP_LO))
         begin
            st_d.cap[sel_t] = {st_q.temp, pwdata[7:0]};
         end
         else if (pwrite)
         begin
            st_d.cw_data = {st_q.temp, pwdata[7:0]};
            st_d.cw_stb[sel_t][sub[2:1] - 2'd1] = 1'b1;
         end
         else if (sub == `TIRQ_SUB_CAP_LO)
         begin
            st_d.temp = st_q.cap[sel_t][15:8];
         end
      end

      // ---- per-timer flags ----
      for (int t = 0; t < 4; t++)
      begin
         // each timer keeps its own flags
         clr = vector_ack[t];
         if (wr & hit_flag & (sel_r == t[1:0]))
         begin
            clr = clr | from_byte(pwdata[7:0]);
         end
         set[0] = overflow[t];
         // A and B one cycle after match
         set[1] = match_a[t];
         set[2] = match_b[t];
         set[3] = match_c[t];
         if (capture_is_top[t])
         begin
            set[4] = top_reached[t];
         end
         else
         begin
            set[4] = pin_evt[t];
         end
         if (pin_evt[t] & ~capture_is_top[t])
         begin
            st_d.cap[t] = count_value[t];
         end
         // compare C clears on vector or one
         // overflow clears on vector or one
         st_d.flag[t] = (st_q.flag[t] & ~clr) | set;
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q.mask <= {4{`TIRQ_MASK_RST}};
         st_q.flag <= {4{`TIRQ_FLAG_RST}};
         st_q.gie <= 1'b0;
         st_q.acsel <= 1'b0;
         st_q.rise <= `TIRQ_RISE_RST;
         st_q.temp <= `TIRQ_TEMP_RST;
         st_q.cap <= {4{`TIRQ_CAP_RST}};
         st_q.s1 <= 5'h00;
         st_q.s2 <= 5'h00;
         st_q.s3 <= 5'h00;
         st_q.lvl <= 5'h00;
         st_q.cw_data <= 16'h0000;
         st_q.cw_stb <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end
endmodule : tirq_top
`default_nettype wire

//--- tirq_map.svh
`ifndef TIRQ_MAP_SVH
`define TIRQ_MAP_SVH
// ****************************************************
// register offsets (byte addresses, 32-bit words)
// ****************************************************
`define TIRQ_MASK_BASE 12'h000
`define TIRQ_FLAG_BASE 12'h010
`define TIRQ_CTRL_OFS 12'h020
`define TIRQ_REQ_OFS 12'h024
`define TIRQ_TMR_BASE 12'h080
`define TIRQ_TMR_MASK 12'hF80
// ****************************************************
// sixteen-bit access slots inside one timer window
// ****************************************************
`define TIRQ_SUB_CAP_LO 3'h0
`define TIRQ_SUB_CAP_HI 3'h1
// ****************************************************
// field positions in mask and flag bytes
// ****************************************************
`define TIRQ_B_CAP 5
`define TIRQ_B_CMPC 3
`define TIRQ_B_CMPB 2
`define TIRQ_B_CMPA 1
`define TIRQ_B_OVF 0
// ****************************************************
// field positions in the control word
// ****************************************************
`define TIRQ_C_GIE 0
`define TIRQ_C_ACSEL 1
`define TIRQ_C_RISE_LO 4
// ****************************************************
// reset values
// ****************************************************
`define TIRQ_MASK_RST 5'h00
`define TIRQ_FLAG_RST 5'h00
`define TIRQ_RISE_RST 4'hF
`define TIRQ_TEMP_RST 8'h00
`define TIRQ_CAP_RST 16'h0000
`endif

//--- tirq_pkg.sv
`default_nettype none
package tirq_pkg;
   typedef logic [15:0] tirq_cnt_t;
   typedef logic [4:0] tirq_src_t;
   typedef logic [2:0] tirq_cmp_t;
   typedef struct packed {
      tirq_src_t [3:0] mask;
      tirq_src_t [3:0] flag;
      logic gie;
      logic acsel;
      logic [3:0] rise;
      logic [7:0] temp;
      tirq_cnt_t [3:0] cap;
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] lvl;
      tirq_cnt_t cw_data;
      tirq_cmp_t [3:0] cw_stb;
   } tirq_state_t;
endpackage : tirq_pkg
`default_nettype wire

//--- tirq_checker.sv
`default_nettype none
// ****************************************
// port-level checks on the timer irq block
// ****************************************
module tirq_checker
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [3:0] match_c,
   input wire logic [3:0] overflow,
   input wire tirq_pkg::tirq_src_t [3:0] vector_ack,
   input wire logic [3:0] compare_c_irq_request,
   input wire logic [3:0] overflow_irq_request,
   input wire tirq_pkg::tirq_cnt_t compare_wr_data,
   input wire tirq_pkg::tirq_cmp_t [3:0] compare_wr_strobe
);
   import tirq_pkg::*;
   logic rd_acc;
   logic wr_acc;
   assign rd_acc = psel && penable && !pwrite;
   assign wr_acc = psel && penable && pwrite;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_mask_rsvd: assert property
      (rd_acc && paddr[11:4] == 8'h00 |-> prdata[7:6] == 2'h0 && !prdata[4])
      else $error("mask reserved bits not zero");
   chk_flag_rsvd: assert property
      (rd_acc && paddr[11:4] == 8'h01 |-> prdata[7:6] == 2'h0 && !prdata[4])
      else $error("flag reserved bits not zero");
   chk_strobe_cause: assert property
      (|compare_wr_strobe |-> $past(wr_acc && paddr[11:7] == 5'h01
         && !paddr[2] && paddr[4:3] != 2'h0))
      else $error("compare strobe without low byte write");
   chk_c_commit: assert property
      (wr_acc && paddr == 12'h0F8 |=> compare_wr_strobe[3] == 3'h4
         && compare_wr_data[7:0] == $past(pwdata[7:0]))
      else $error("compare c low write not committed");
   chk_strobe_once: assert property
      (|compare_wr_strobe |=> !(|compare_wr_strobe))
      else $error("compare strobe longer than one cycle");
   chk_c_req_rise: assert property
      ($rose(compare_c_irq_request[1]) |-> $past(match_c[1] || wr_acc))
      else $error("compare c request rose without cause");
   chk_c_req_fall: assert property
      ($fell(compare_c_irq_request[1]) |-> $past(vector_ack[1][3] || wr_acc))
      else $error("compare c request fell without clear");
   chk_ovf_ack: assert property
      (vector_ack[1][0] && !overflow[1] |=> !overflow_irq_request[1])
      else $error("overflow request kept after vector");
   cov_cmp_c: cover property (compare_wr_strobe[3] == 3'h4);
   cov_c_req: cover property ($rose(compare_c_irq_request[1]));
   cov_ack: cover property (vector_ack[1][0]);
endmodule : tirq_checker

bind tirq_top tirq_checker chk
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .match_c, .overflow, .vector_ack, .compare_c_irq_request,
   .overflow_irq_request, .compare_wr_data, .compare_wr_strobe
);
`default_nettype wire

//--- timer16_irq_capture_flags_test.sv
`default_nettype none
`include "tirq_map.svh"
module timer16_irq_capture_flags_test;
   timeunit 1ns;
   timeprecision 1ps;
   import tirq_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   tirq_cnt_t [3:0] count_value, capture_register;
   tirq_src_t [3:0] vector_ack;
   tirq_cmp_t [3:0] compare_wr_strobe;
   tirq_cnt_t compare_wr_data;
   logic [3:0] capture_input_pin, match_a, match_b, match_c, overflow;
   logic [3:0] top_reached, capture_is_top, cap_rq, c_rq, b_rq, a_rq, o_rq;
   logic err_seen;
   int bad_count, num_checks;

   tirq_top uut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .count_value, .capture_input_pin,
      .comparator_out(cmp_out), .match_a, .match_b, .match_c, .overflow,
      .top_reached, .capture_is_top, .vector_ack,
      .capture_irq_request(cap_rq), .compare_c_irq_request(c_rq),
      .compare_b_irq_request(b_rq), .compare_a_irq_request(a_rq),
      .overflow_irq_request(o_rq), .capture_register, .compare_wr_data,
      .compare_wr_strobe
   );

   initial
   begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // bounded wait: pready is never assumed, only sampled
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         bad_count++;
         stop_test();
      end
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : xfer

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : reg_wr

   task automatic reg_rd(input logic [11:0] a, input logic [31:0] e,
      input string name);
      xfer(1'b0, a, 32'h0);
      check(name, e, rd);
   endtask : reg_rd

   task automatic ack(input tirq_src_t v);
      @(posedge pclk);
      vector_ack[1] <= v;
      @(posedge pclk);
      vector_ack[1] <= 5'h00;
      #1;
   endtask : ack

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, cmp_out} = '0;
      {count_value, capture_input_pin, match_a, match_b, match_c} = '0;
      {overflow, top_reached, capture_is_top, vector_ack} = '0;
      bad_count = 0;
      num_checks = 0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         reg_rd(`TIRQ_MASK_BASE + 12'(4 * k), 32'h0, "mask");
         reg_rd(`TIRQ_FLAG_BASE + 12'(4 * k), 32'h0, "flag");
      end
      reg_wr(`TIRQ_MASK_BASE, 32'hFF);
      reg_rd(`TIRQ_MASK_BASE, 32'h2F, "mask t1");
      reg_rd(`TIRQ_MASK_BASE + 12'h4, 32'h0, "mask t3");
      // every event source of timer 3 in one cycle
      @(posedge pclk);
      {match_a[1], match_b[1], match_c[1], overflow[1], top_reached[1]} <= '1;
      capture_is_top[1] <= 1'b1;
      @(posedge pclk);
      {match_a[1], match_b[1], match_c[1], overflow[1], top_reached[1]} <= '0;
      reg_rd(`TIRQ_FLAG_BASE + 12'h4, 32'h2F, "flag t3");
      reg_wr(`TIRQ_FLAG_BASE + 12'h4, 32'h0);
      reg_rd(`TIRQ_FLAG_BASE + 12'h4, 32'h2F, "flag kept");
      // rising edges on every timer, global enable on
      reg_wr(`TIRQ_CTRL_OFS, 32'hF1);
      reg_wr(`TIRQ_MASK_BASE + 12'h4, 32'h2F);
      check("req", 32'h1F, {cap_rq[1], c_rq[1], b_rq[1], a_rq[1], o_rq[1]});
      reg_wr(`TIRQ_FLAG_BASE + 12'h4, 32'h08);
      check("req c clr", 32'h17, {cap_rq[1], c_rq[1], b_rq[1], a_rq[1], o_rq[1]});
      capture_is_top[1] <= 1'b0;
      ack(5'h11);
      reg_rd(`TIRQ_FLAG_BASE + 12'h4, 32'h06, "flag ack");
      // hardware set of A lands on the edge of a write-one clear of A
      fork
         reg_wr(`TIRQ_FLAG_BASE + 12'h4, 32'h02);
         begin
            repeat (2) @(posedge pclk);
            match_a[1] <= 1'b1;
            @(posedge pclk);
            match_a[1] <= 1'b0;
         end
      join
      reg_rd(`TIRQ_FLAG_BASE + 12'h4, 32'h06, "set wins");
      reg_wr(`TIRQ_CTRL_OFS, 32'hF0);
      check("req gie off", 32'h0, {cap_rq[1], a_rq[1], b_rq[1]});
      // capture on timer 4; counter moves on after the edge
      @(posedge pclk);
      count_value[2] <= 16'hABCD;
      capture_input_pin[2] <= 1'b1;
      repeat (6) @(posedge pclk);
      count_value[2] <= 16'h0000;
      reg_rd(`TIRQ_FLAG_BASE + 12'h8, 32'h20, "cap flag");
      reg_rd(`TIRQ_TMR_BASE + 12'h40, 32'hCD, "cap lo");
      reg_rd(`TIRQ_TMR_BASE + 12'h44, 32'hAB, "cap hi");
      check("cap out", 32'hABCD, capture_register[2]);
      reg_wr(`TIRQ_FLAG_BASE + 12'h8, 32'h20);
      reg_rd(`TIRQ_FLAG_BASE + 12'h8, 32'h0, "cap clr");
      // timer 1 takes its capture from the comparator instead of its pin
      reg_wr(`TIRQ_CTRL_OFS, 32'hF2);
      @(posedge pclk);
      count_value[0] <= 16'h5A3C;
      cmp_out <= 1'b1;
      repeat (6) @(posedge pclk);
      count_value[0] <= 16'h0000;
      reg_rd(`TIRQ_FLAG_BASE, 32'h20, "comp flag");
      reg_rd(`TIRQ_TMR_BASE, 32'h3C, "comp lo");
      reg_rd(`TIRQ_TMR_BASE + 12'h4, 32'h5A, "comp hi");
      // high byte through timer 1, low byte into timer 5
      reg_wr(`TIRQ_TMR_BASE + 12'h1C, 32'h12);
      reg_wr(`TIRQ_TMR_BASE + 12'h78, 32'h34);
      check("cmp data", 32'h1234, compare_wr_data);
      check("cmp strobe", 32'h4, compare_wr_strobe[3]);
      reg_rd(12'h040, 32'h0, "unmapped");
      check("slverr", 32'h1, err_seen);
      stop_test();
   end
endmodule : timer16_irq_capture_flags_test
`default_nettype wire
